//--- rst_sup_pkg.sv
// constants and carrier types for the supervisory reset generator
// Overview of operation
// [R1] any of four sources raises internal reset
// [R2] core and companion reset together
// [R3] core held in reset, restarts at zero
// [R4] companion reset is driven active low
// [R5] low level on reset pin requests reset
// [R6] short low spikes on pin ignored
// [R7] outside holds pin low long enough
// [R8] pin reset ends when pin releases
// [R9] supply reset held after supply recovers
// [R10] supply detector can never be disabled
// [R11] short supply dips are rejected
// [R12] supply reset sets cold start flag
// [R13] cold start flag readable by software
// [R14] only software write clears cold flag
// [R15] debug reset works in sleep modes
// [R16] watchdog overflow reloads disable key
// [R17] reset release synchronous to clock
package rst_sup_pkg;
  localparam int          CLK_PERIOD_NS             = 4;
  localparam int          SPIKE_FILTER_TIME_NS      = 100;
  localparam int          SPIKE_FILTER_CYC          = (SPIKE_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SUPPLY_RESET_HOLD_TIME_NS = 10000;
  localparam int          SUPPLY_RESET_HOLD_CYC     =
    (SUPPLY_RESET_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WD_RESET_TIME_NS          = 16;
  localparam int          WD_RESET_CYC              = WD_RESET_TIME_NS / CLK_PERIOD_NS;
  localparam int          WD_COUNT_W                = 24;
  localparam int          WD_KEY_W                  = 8;
  localparam logic [7:0]  WD_KEY_DISABLE            = 8'h55;
  localparam logic [15:0] RESET_VECTOR              = 16'h0000;
  // pin synchroniser starts at the idle high level of the pin
  localparam logic [1:0]  SYNC_RESET_VAL            = 2'h3;

  typedef struct packed {
    logic       key_wr;
    logic       reload_wr;
    logic [7:0] data;
  } wd_write_t;
endpackage : rst_sup_pkg

//--- spike_filter.sv
// level qualifier: output rises only after input held a full window
`timescale 1ns/1ps
module spike_filter #(
  parameter int CYCLES = 25
) (
  input  wire logic sys_clk_in,
  input  wire logic arst_n_in,
  input  wire logic level_in,
  output logic      level_out
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          out;
  } filt_state_t;

  filt_state_t s_q;
  filt_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (!level_in) begin
      s_d.cnt = '0;
      s_d.out = 1'b0;
    end else if (s_q.cnt >= LAST) begin // [R6]
      s_d.out = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.out;

  property p_spike_reject;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      $rose(level_in) |=> !level_out [*2];
  endproperty
  a_spike_reject: assert property (p_spike_reject) else $error("filter passed a fresh edge"); // [R6]

  property p_release_now;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      !level_in |=> !level_out;
  endproperty
  a_release_now: assert property (p_release_now) else $error("filter stretched a release"); // [R8]
endmodule : spike_filter

//--- supervisory_reset_generator.sv
// reset combiner, supply hold, watchdog and cold start flag
`timescale 1ns/1ps
module supervisory_reset_generator #(
  parameter int FILTER_CYC = rst_sup_pkg::SPIKE_FILTER_CYC,
  parameter int HOLD_CYC   = rst_sup_pkg::SUPPLY_RESET_HOLD_CYC,
  parameter int WD_PULSE   = rst_sup_pkg::WD_RESET_CYC,
  parameter int WD_W       = rst_sup_pkg::WD_COUNT_W
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   arst_n_in,
  input  wire logic                   ext_reset_n_in,
  input  wire logic                   low_supply_in,
  input  wire logic                   debug_reset_in,
  input  wire logic                   cpu_sleep_in,
  input  wire logic                   machine_cycle_in,
  input  wire rst_sup_pkg::wd_write_t wd_write_in,
  input  wire logic                   cold_start_clr_in,
  output logic                        core_reset_out,
  output logic                        companion_reset_n_out,
  output logic [15:0]                 fetch_addr_out,
  output logic                        cold_start_flag_out,
  output logic                        watchdog_enabled_out
);
  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int PW = $clog2(WD_PULSE + 1);

  typedef struct packed {
    logic [1:0]                      pin_sync;
    logic [1:0]                      sup_sync;
    logic [1:0]                      dbg_sync;
    logic [HW-1:0]                   hold_cnt;
    logic [WD_W-1:0]                 wd_cnt;
    logic [rst_sup_pkg::WD_KEY_W-1:0] wd_key;
    logic [PW-1:0]                   wd_pulse;
    logic                            core_rst;
    logic                            comp_rst_n;
    logic                            cold_flag;
    logic                            wd_en;
    logic [15:0]                     fetch_addr;
  } sup_state_t;

  sup_state_t s_q;
  sup_state_t s_d;
  logic       pin_active;
  logic       sup_active;
  logic       supply_rst;
  logic       wd_fire;
  logic       any_src;

  // counting only on awake machine cycles of an armed watchdog
  function automatic logic wd_counts(input logic armed, input logic step, input logic sleep);
    return armed && step && !sleep;
  endfunction : wd_counts

  spike_filter #(.CYCLES(FILTER_CYC)) u_pin_filter (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .level_in   (~s_q.pin_sync[1]), // [R5]
    .level_out  (pin_active)
  );

  spike_filter #(.CYCLES(FILTER_CYC)) u_supply_filter (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .level_in   (s_q.sup_sync[1]), // [R11]
    .level_out  (sup_active)
  );

  always_comb begin
    supply_rst = sup_active || (s_q.hold_cnt != '0); // [R9] [R10]
    wd_fire    = wd_counts(s_q.wd_en, machine_cycle_in, cpu_sleep_in) && (&s_q.wd_cnt);
    any_src    = pin_active || supply_rst || s_q.dbg_sync[1] || (s_q.wd_pulse != '0); // [R1] [R15]
  end

  always_comb begin
    s_d          = s_q;
    s_d.pin_sync = {s_q.pin_sync[0], ext_reset_n_in};
    s_d.sup_sync = {s_q.sup_sync[0], low_supply_in};
    s_d.dbg_sync = {s_q.dbg_sync[0], debug_reset_in};

    // supply hold restarts on every dip that passes the filter and counts down after recovery
    if (sup_active) begin
      s_d.hold_cnt = HW'(HOLD_CYC); // [R9]
    end else if (s_q.hold_cnt != '0) begin
      s_d.hold_cnt = s_q.hold_cnt - HW'(1);
    end

    // registered combine, both reset outputs move on one edge
    s_d.core_rst   = any_src; // [R17] [R2]
    s_d.comp_rst_n = ~any_src; // [R4] [R2]
    s_d.fetch_addr = any_src ? rst_sup_pkg::RESET_VECTOR : s_q.fetch_addr; // [R3]

    // cold start flag: set wins over software clear
    if (sup_active) begin
      s_d.cold_flag = 1'b1; // [R12]
    end else if (cold_start_clr_in) begin
      s_d.cold_flag = 1'b0; // [R14]
    end

    // watchdog
    if (s_q.wd_pulse != '0) begin
      s_d.wd_pulse = s_q.wd_pulse - PW'(1);
    end
    if (s_q.core_rst) begin
      s_d.wd_key = rst_sup_pkg::WD_KEY_DISABLE;
      s_d.wd_cnt = '0;
    end else if (wd_fire) begin
      s_d.wd_key   = rst_sup_pkg::WD_KEY_DISABLE; // [R16]
      s_d.wd_cnt   = '0;
      s_d.wd_pulse = PW'(WD_PULSE);
    end else begin
      if (wd_write_in.key_wr) begin
        s_d.wd_key = wd_write_in.data;
      end
      if (wd_write_in.reload_wr) begin
        s_d.wd_cnt = {wd_write_in.data, (WD_W - 8)'(0)};
      end else if (wd_counts(s_q.wd_en, machine_cycle_in, cpu_sleep_in)) begin
        s_d.wd_cnt = s_q.wd_cnt + WD_W'(1);
      end
    end
    s_d.wd_en = (s_d.wd_key != rst_sup_pkg::WD_KEY_DISABLE);
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q            <= '0;
      s_q.pin_sync   <= rst_sup_pkg::SYNC_RESET_VAL;
      s_q.wd_key     <= rst_sup_pkg::WD_KEY_DISABLE;
      s_q.core_rst   <= 1'b1;
      s_q.comp_rst_n <= 1'b0;
      s_q.cold_flag  <= 1'b1;
      s_q.fetch_addr <= rst_sup_pkg::RESET_VECTOR;
    end else begin
      s_q <= s_d;
    end
  end

  assign core_reset_out        = s_q.core_rst;
  assign companion_reset_n_out = s_q.comp_rst_n;
  assign fetch_addr_out        = s_q.fetch_addr;
  assign cold_start_flag_out   = s_q.cold_flag; // [R13]
  assign watchdog_enabled_out  = s_q.wd_en;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_any_source;
    any_src |=> core_reset_out;
  endproperty
  a_any_source: assert property (p_any_source) else $error("source did not raise reset"); // [R1]

  property p_same_edge;
    core_reset_out == !companion_reset_n_out;
  endproperty
  a_same_edge: assert property (p_same_edge) else $error("core and companion reset differ"); // [R2]

  property p_comp_low;
    $fell(companion_reset_n_out) |-> $rose(core_reset_out);
  endproperty
  a_comp_low: assert property (p_comp_low) else $error("companion reset not active low"); // [R4]

  property p_vector;
    core_reset_out |-> fetch_addr_out == rst_sup_pkg::RESET_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("fetch address not zero in reset"); // [R3]

  property p_pin_release;
    $fell(pin_active) && !supply_rst && !s_q.dbg_sync[1] && s_q.wd_pulse == '0 |=> !core_reset_out;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin reset stretched"); // [R8]

  sequence s_supply_back;
    $fell(sup_active);
  endsequence
  property p_supply_hold;
    s_supply_back |=> core_reset_out [*8];
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("supply reset released early"); // [R9]

  property p_cold_set;
    sup_active |=> cold_start_flag_out;
  endproperty
  a_cold_set: assert property (p_cold_set) else $error("cold flag not set"); // [R12]

  property p_cold_keep;
    cold_start_flag_out && !cold_start_clr_in |=> cold_start_flag_out;
  endproperty
  a_cold_keep: assert property (p_cold_keep) else $error("cold flag lost without clear"); // [R14]

  sequence s_wd_over;
    wd_fire && !s_q.core_rst;
  endsequence
  property p_wd_disable;
    s_wd_over |=> !watchdog_enabled_out ##1 core_reset_out;
  endproperty
  a_wd_disable: assert property (p_wd_disable) else $error("watchdog not disabled on overflow"); // [R16]

  property p_debug_sleep;
    s_q.dbg_sync[1] && cpu_sleep_in |=> core_reset_out;
  endproperty
  a_debug_sleep: assert property (p_debug_sleep) else $error("debug reset lost in sleep"); // [R15]

  property p_supply_sleep;
    sup_active && cpu_sleep_in |=> core_reset_out;
  endproperty
  a_supply_sleep: assert property (p_supply_sleep) else $error("supply reset lost in sleep"); // [R10]

  property p_hold_reload;
    sup_active |=> s_q.hold_cnt == HW'(HOLD_CYC);
  endproperty
  a_hold_reload: assert property (p_hold_reload) else $error("supply hold not restarted"); // [R9]

  property p_cold_clear;
    cold_start_clr_in && !sup_active |=> !cold_start_flag_out;
  endproperty
  a_cold_clear: assert property (p_cold_clear) else $error("cold flag not cleared by software"); // [R14]

  property p_wd_reset_key;
    core_reset_out |=> !watchdog_enabled_out;
  endproperty
  a_wd_reset_key: assert property (p_wd_reset_key) else $error("watchdog armed during reset"); // [R16]

  property p_release_sync;
    $fell(core_reset_out) |-> !$past(any_src);
  endproperty
  a_release_sync: assert property (p_release_sync) else $error("reset released with source active"); // [R17]
endmodule : supervisory_reset_generator

//--- reset_sources_model.sv
// far-side model: reset switch, supply monitor, debug probe
`timescale 1ns/1ps
module reset_sources_model (
  input  wire logic sys_clk_in,
  output logic      ext_reset_n_out,
  output logic      low_supply_out,
  output logic      debug_reset_out
);
  logic [2:0] act_q = 3'h0;
  assign ext_reset_n_out = ~act_q[0];
  assign low_supply_out  = act_q[1];
  assign debug_reset_out = act_q[2];
  // source sel active for n cycles; a real press keeps n past the filter
  task automatic hold(input int sel, input int n);
    @(posedge sys_clk_in) act_q[sel] <= 1'b1;
    repeat (n) @(posedge sys_clk_in);
    act_q[sel] <= 1'b0;
    #1;
  endtask : hold
endmodule : reset_sources_model

//--- supervisory_reset_generator_test.sv
// self-checking bench for the supervisory reset generator
`timescale 1ns/1ps
module supervisory_reset_generator_test;
  localparam int FC = 3;
  localparam int HC = 10;
  logic                   sys_clk_in        = 1'b0;
  logic                   arst_n_in         = 1'b0;
  logic                   cpu_sleep_in      = 1'b0;
  logic                   machine_cycle_in  = 1'b0;
  logic                   cold_start_clr_in = 1'b0;
  rst_sup_pkg::wd_write_t wd_write_in       = '0;
  logic                   ext_n, low_s, dbg, core, comp_n, cold, wd_en;
  logic [15:0]            fetch;
  int                     n_mismatch        = 0;
  int                     n_checks          = 0;
  int                     c;
  always #2 sys_clk_in = ~sys_clk_in;
  reset_sources_model far (.sys_clk_in(sys_clk_in), .ext_reset_n_out(ext_n), .low_supply_out(low_s),
    .debug_reset_out(dbg));
  supervisory_reset_generator #(.FILTER_CYC(FC), .HOLD_CYC(HC), .WD_PULSE(4), .WD_W(10)) uut (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .ext_reset_n_in(ext_n), .low_supply_in(low_s),
    .debug_reset_in(dbg), .cpu_sleep_in(cpu_sleep_in), .machine_cycle_in(machine_cycle_in),
    .wd_write_in(wd_write_in), .cold_start_clr_in(cold_start_clr_in), .core_reset_out(core),
    .companion_reset_n_out(comp_n), .fetch_addr_out(fetch), .cold_start_flag_out(cold),
    .watchdog_enabled_out(wd_en));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick
  // bounded waits for core reset to reach a level
  task automatic wait_lvl(input logic lvl, output int n);
    n = 0;
    while (core !== lvl && n < 2000) begin
      tick(1);
      n++;
    end
  endtask : wait_lvl
  task automatic t_power_up();
    wait_lvl(1'b0, c);
    chk("release", 16'h1, 16'(c < 6));
    chk("fetch", 16'h0000, fetch);
    chk("cold", 16'h1, 16'(cold));
    chk("wd_en", 16'h0, 16'(wd_en));
    chk("comp_n", 16'h1, 16'(comp_n));
  endtask : t_power_up
  task automatic t_spikes();
    @(posedge sys_clk_in) cold_start_clr_in <= 1'b1;
    @(posedge sys_clk_in) cold_start_clr_in <= 1'b0;
    tick(2);
    chk("cold_clr", 16'h0, 16'(cold));
    far.hold(0, FC - 1);
    far.hold(1, FC - 1);
    tick(8);
    chk("spike", 16'h0, 16'(core));
    chk("cold_dip", 16'h0, 16'(cold));
  endtask : t_spikes
  task automatic t_pin();
    far.hold(0, 20);
    chk("pin_rst", 16'h1, 16'(core));
    chk("pin_comp", 16'h0, 16'(comp_n));
    chk("pin_fetch", 16'h0000, fetch);
    wait_lvl(1'b0, c);
    chk("pin_end", 16'h1, 16'(c < 6));
    chk("cold_pin", 16'h0, 16'(cold));
  endtask : t_pin
  // supply dip while the processor sleeps
  task automatic t_supply();
    @(posedge sys_clk_in) cpu_sleep_in <= 1'b1;
    far.hold(1, 20);
    chk("sup_rst", 16'h1, 16'(core));
    chk("cold_sup", 16'h1, 16'(cold));
    wait_lvl(1'b0, c);
    chk("sup_hold", 16'h1, 16'(c >= HC && c < HC + 8));
  endtask : t_supply
  task automatic t_debug();
    @(posedge sys_clk_in) cpu_sleep_in <= 1'b1;
    far.hold(2, 3);
    wait_lvl(1'b1, c);
    chk("dbg_rst", 16'h1, 16'(c < 4));
    wait_lvl(1'b0, c);
    @(posedge sys_clk_in) cpu_sleep_in <= 1'b0;
  endtask : t_debug
  task automatic t_watchdog();
    @(posedge sys_clk_in) wd_write_in <= '{key_wr: 1'b1, reload_wr: 1'b0, data: 8'hAA};
    @(posedge sys_clk_in) wd_write_in <= '0;
    tick(2);
    chk("wd_on", 16'h1, 16'(wd_en));
    @(posedge sys_clk_in) machine_cycle_in <= 1'b1;
    wait_lvl(1'b1, c);
    chk("wd_fire", 16'h1, 16'(c > 1000 && c < 1040));
    @(posedge sys_clk_in) machine_cycle_in <= 1'b0;
    wait_lvl(1'b0, c);
    chk("wd_off", 16'h0, 16'(wd_en));
    chk("wd_cold", 16'h1, 16'(cold));
  endtask : t_watchdog
  // reload of the top byte to half range halves the time to overflow
  task automatic t_wd_reload();
    @(posedge sys_clk_in) wd_write_in <= '{key_wr: 1'b1, reload_wr: 1'b0, data: 8'h3C};
    @(posedge sys_clk_in) wd_write_in <= '{key_wr: 1'b0, reload_wr: 1'b1, data: 8'h80};
    @(posedge sys_clk_in) wd_write_in <= '0;
    @(posedge sys_clk_in) machine_cycle_in <= 1'b1;
    wait_lvl(1'b1, c);
    chk("wd_reload", 16'h1, 16'(c > 500 && c < 530));
    @(posedge sys_clk_in) machine_cycle_in <= 1'b0;
    wait_lvl(1'b0, c);
    chk("wd_reload_off", 16'h0, 16'(wd_en));
  endtask : t_wd_reload
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    #20000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    tick(1);
    t_power_up();
    t_spikes();
    t_pin();
    t_supply();
    t_debug();
    t_watchdog();
    t_wd_reload();
    end_sim();
  end
endmodule : supervisory_reset_generator_test
